//--- common/ctd_pkg.sv
package ctd_pkg;

    // Instruction encoding
    localparam logic [1:0] CTD_PRIMARY_OP = 2'h2;
    localparam logic [5:0] CTD_OP_EXT = 6'h3a;
    localparam int CTD_OP_HI = 31;
    localparam int CTD_OP_LO = 30;
    localparam int CTD_RSV_TOP = 29;
    localparam int CTD_COND_HI = 28;
    localparam int CTD_COND_LO = 25;
    localparam int CTD_EXT_HI = 24;
    localparam int CTD_EXT_LO = 19;
    localparam int CTD_IMM_FLAG = 13;
    localparam int CTD_GRP_HI = 12;
    localparam int CTD_GRP_LO = 11;
    localparam int CTD_RSVR_HI = 12;
    localparam int CTD_RSVR_LO = 5;
    localparam int CTD_RSVI_HI = 10;
    localparam int CTD_RSVI_LO = 8;
    localparam int CTD_IMM_HI = 7;
    localparam int CTD_IMM_LO = 0;

    // Flag register halves
    localparam int CTD_WFLAG_HI = 3;
    localparam int CTD_WFLAG_LO = 0;
    localparam int CTD_DFLAG_HI = 7;
    localparam int CTD_DFLAG_LO = 4;

    // Trap number and type
    localparam int CTD_NUM_W = 8;
    localparam int CTD_USER_NUM_W = 7;
    localparam int CTD_TT_W = 9;
    localparam int CTD_TL_W = 3;
    localparam logic [8:0] CTD_TT_BASE = 9'h100;
    localparam logic [8:0] CTD_TT_ORD_MAX = 9'h17f;
    localparam logic [8:0] CTD_TT_HYP_MIN = 9'h180;
    localparam logic [8:0] CTD_TT_HYP_MAX = 9'h1ff;

    // Register map, byte addresses
    localparam int CTD_AW = 5;
    localparam logic [4:0] CTD_REG_CTRL = 5'h00;
    localparam logic [4:0] CTD_REG_STATUS = 5'h04;
    localparam logic [4:0] CTD_REG_MASK = 5'h08;
    localparam logic [4:0] CTD_REG_LAST = 5'h0c;
    localparam logic [4:0] CTD_REG_COUNT = 5'h10;
    localparam int CTD_CTRL_EN = 0;
    localparam logic CTD_CTRL_RESET = 1'h1;
    localparam logic [3:0] CTD_MASK_RESET = 4'h0;
    localparam int CTD_CNT_W = 16;

    // Event bits in status and mask
    localparam int CTD_EV_W = 4;
    localparam int CTD_EV_TRAP = 0;
    localparam int CTD_EV_HTRAP = 1;
    localparam int CTD_EV_ILLEGAL = 2;
    localparam int CTD_EV_NOP = 3;

    typedef enum logic [3:0] {
        CTD_C_NEVER = 4'h0,
        CTD_C_EQ = 4'h1,
        CTD_C_LE = 4'h2,
        CTD_C_LT = 4'h3,
        CTD_C_LEU = 4'h4,
        CTD_C_CS = 4'h5,
        CTD_C_NEG = 4'h6,
        CTD_C_VS = 4'h7,
        CTD_C_ALWAYS = 4'h8,
        CTD_C_NE = 4'h9,
        CTD_C_GT = 4'ha,
        CTD_C_GE = 4'hb,
        CTD_C_GTU = 4'hc,
        CTD_C_CC = 4'hd,
        CTD_C_POS = 4'he,
        CTD_C_VC = 4'hf
    } ctd_cond_t;

    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } ctd_flags_t;

    typedef struct packed {
        logic valid;
        logic trap;
        logic hyper;
        logic illegal;
        logic noEffect;
        logic [2:0] level;
        logic [8:0] trapTypeValue;
    } ctd_result_t;

    function automatic logic ctd_is_op(input logic [31:0] instr);
        return instr[CTD_OP_HI:CTD_OP_LO] == CTD_PRIMARY_OP
            && instr[CTD_EXT_HI:CTD_EXT_LO] == CTD_OP_EXT;
    endfunction : ctd_is_op

endpackage : ctd_pkg

//--- design/ctd_cond_eval.sv
module ctd_cond_eval
    import ctd_pkg::*;
(
    input wire ctd_flags_t flags,
    input wire logic [3:0] cond,
    output logic testTrue
);

    always_comb begin
        unique case (ctd_cond_t'(cond))
            CTD_C_ALWAYS: testTrue = 1'b1;
            CTD_C_NEVER: testTrue = 1'b0;
            CTD_C_NE: testTrue = !flags.z;
            CTD_C_EQ: testTrue = flags.z;
            CTD_C_GT: testTrue = !(flags.z || (flags.n ^ flags.v));
            CTD_C_LE: testTrue = flags.z || (flags.n ^ flags.v);
            CTD_C_GE: testTrue = !(flags.n ^ flags.v);
            CTD_C_LT: testTrue = flags.n ^ flags.v;
            CTD_C_GTU: testTrue = !(flags.c || flags.z);
            CTD_C_LEU: testTrue = flags.c || flags.z;
            CTD_C_CC: testTrue = !flags.c;
            CTD_C_CS: testTrue = flags.c;
            CTD_C_POS: testTrue = !flags.n;
            CTD_C_NEG: testTrue = flags.n;
            CTD_C_VC: testTrue = !flags.v;
            CTD_C_VS: testTrue = flags.v;
        endcase
    end

endmodule : ctd_cond_eval

//--- design/conditional_trap_decoder.sv
// Local design decisions: the register addresses and the Avalon-MM slave port.
module conditional_trap_decoder
    import ctd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic instrValid,
    input wire logic [31:0] instrWord,
    input wire logic [63:0] firstSourceRegister,
    input wire logic [63:0] secondSourceRegister,
    input wire logic [7:0] flagRegister,
    input wire logic privilegeFlag,
    input wire logic higherPending,
    input wire logic [2:0] trapLevel,
    output ctd_result_t result,
    output logic trapEntryReq,
    input wire logic [4:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    output logic irq
);

    logic decodeHit;
    logic illegalEnc;
    logic immFlag;
    logic [1:0] flagGroup;
    ctd_flags_t groupFlags;
    logic testTrue;
    logic [7:0] addend;
    logic [7:0] sum;
    logic [7:0] softwareTrapNumber;
    logic takeTrap;
    ctd_result_t next_result;
    logic next_trapEntryReq;

    logic ctrlEnable;
    logic [3:0] status;
    logic [3:0] mask;
    logic [8:0] lastType;
    logic [15:0] trapCount;
    logic next_ctrlEnable;
    logic [3:0] next_status;
    logic [3:0] next_mask;
    logic [8:0] next_lastType;
    logic [15:0] next_trapCount;
    logic next_irq;
    logic [31:0] next_avsReadData;
    logic next_avsWaitRequest;
    logic busWrite;
    logic [3:0] events;

    assign immFlag = instrWord[CTD_IMM_FLAG];
    assign flagGroup = instrWord[CTD_GRP_HI:CTD_GRP_LO];

    ctd_cond_eval ctd_cond_eval_i (
        .flags(groupFlags),
        .cond(instrWord[CTD_COND_HI:CTD_COND_LO]),
        .testTrue(testTrue)
    );

    // Decode and trap-number formation
    always_comb begin
        decodeHit = instrValid && ctrlEnable && ctd_is_op(instrWord);
        illegalEnc = instrWord[CTD_RSV_TOP];
        if (!immFlag && instrWord[CTD_RSVR_HI:CTD_RSVR_LO] != '0) begin
            illegalEnc = 1'b1;
        end
        if (immFlag && instrWord[CTD_RSVI_HI:CTD_RSVI_LO] != '0) begin
            illegalEnc = 1'b1;
        end
        if (flagGroup[0]) begin
            illegalEnc = 1'b1;
        end
        // High group bit alone picks the half once the low bit is known clear
        groupFlags = flagGroup[1] ? ctd_flags_t'(flagRegister[CTD_DFLAG_HI:CTD_DFLAG_LO])
                                  : ctd_flags_t'(flagRegister[CTD_WFLAG_HI:CTD_WFLAG_LO]);
        // Only the low byte of the sum matters; upper bits are left to software
        addend = immFlag ? instrWord[CTD_IMM_HI:CTD_IMM_LO]
                         : secondSourceRegister[CTD_NUM_W-1:0];
        sum = 8'(firstSourceRegister[CTD_NUM_W-1:0] + addend);
        if (privilegeFlag) begin
            softwareTrapNumber = sum;
        end else begin
            softwareTrapNumber = {1'b0, sum[CTD_USER_NUM_W-1:0]};
        end
        takeTrap = decodeHit && !illegalEnc && testTrue && !higherPending;
        next_result.valid = decodeHit;
        next_result.trap = takeTrap;
        next_result.hyper = takeTrap && softwareTrapNumber[CTD_NUM_W-1];
        next_result.illegal = decodeHit && illegalEnc;
        next_result.noEffect = decodeHit && !illegalEnc && !takeTrap;
        next_result.level = trapLevel;
        next_result.trapTypeValue = 9'(CTD_TT_BASE + {1'b0, softwareTrapNumber});
        next_trapEntryReq = takeTrap;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            result <= '0;
            trapEntryReq <= 1'b0;
        end else begin
            result <= next_result;
            trapEntryReq <= next_trapEntryReq;
        end
    end

    // Register file and Avalon slave
    always_comb begin
        // One wait cycle per access; the write lands when waitrequest is low
        busWrite = avsWrite && !avsWaitRequest;
        next_avsWaitRequest = !((avsRead || avsWrite) && avsWaitRequest);
        events = '0;
        events[CTD_EV_TRAP] = result.trap && !result.hyper;
        events[CTD_EV_HTRAP] = result.hyper;
        events[CTD_EV_ILLEGAL] = result.illegal;
        events[CTD_EV_NOP] = result.noEffect;
        next_ctrlEnable = ctrlEnable;
        next_mask = mask;
        next_status = status;
        next_lastType = lastType;
        next_trapCount = trapCount;
        if (busWrite && avsAddress == CTD_REG_CTRL) begin
            next_ctrlEnable = avsWriteData[CTD_CTRL_EN];
        end
        if (busWrite && avsAddress == CTD_REG_MASK) begin
            next_mask = avsWriteData[CTD_EV_W-1:0];
        end
        if (busWrite && avsAddress == CTD_REG_STATUS) begin
            next_status = status & ~avsWriteData[CTD_EV_W-1:0];
        end
        if (busWrite && avsAddress == CTD_REG_COUNT) begin
            next_trapCount = '0;
        end
        // Set wins over a clear in the same cycle
        next_status = next_status | events;
        if (result.trap) begin
            next_lastType = result.trapTypeValue;
            next_trapCount = 16'(next_trapCount + 16'h0001);
        end
        next_irq = |(next_status & next_mask);
        next_avsReadData = '0;
        if (avsRead && avsWaitRequest) begin
            unique case (avsAddress)
                CTD_REG_CTRL: next_avsReadData = {31'h0, ctrlEnable};
                CTD_REG_STATUS: next_avsReadData = {28'h0, status};
                CTD_REG_MASK: next_avsReadData = {28'h0, mask};
                CTD_REG_LAST: next_avsReadData = {23'h0, lastType};
                CTD_REG_COUNT: next_avsReadData = {16'h0, trapCount};
                default: next_avsReadData = '0;
            endcase
        end else if (avsRead) begin
            next_avsReadData = avsReadData;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrlEnable <= CTD_CTRL_RESET;
            mask <= CTD_MASK_RESET;
            status <= '0;
            lastType <= '0;
            trapCount <= '0;
            irq <= 1'b0;
            avsReadData <= '0;
            avsWaitRequest <= 1'b1;
        end else begin
            ctrlEnable <= next_ctrlEnable;
            mask <= next_mask;
            status <= next_status;
            lastType <= next_lastType;
            trapCount <= next_trapCount;
            irq <= next_irq;
            avsReadData <= next_avsReadData;
            avsWaitRequest <= next_avsWaitRequest;
        end
    end

    // Checks
    opcode_hit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        result.valid == $past(instrValid && ctrlEnable && ctd_is_op(instrWord)))
        else $error("decode hit does not follow opcode match");

    never_test_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (decodeHit && instrWord[CTD_COND_HI:CTD_COND_LO] == CTD_C_NEVER) |=> !result.trap)
        else $error("never test raised a trap");

    always_test_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (decodeHit && !illegalEnc && !higherPending
         && instrWord[CTD_COND_HI:CTD_COND_LO] == CTD_C_ALWAYS) |=> result.trap)
        else $error("always test did not trap");

    illegal_wins_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        result.illegal |-> !result.trap && !result.hyper && !trapEntryReq)
        else $error("illegal encoding raised a software trap");

    top_bit_illegal_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (decodeHit && instrWord[CTD_RSV_TOP]) |=> result.illegal)
        else $error("bit 29 set not flagged illegal");

    group_low_illegal_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (decodeHit && instrWord[CTD_GRP_LO]) |=> result.illegal)
        else $error("group low bit set not flagged illegal");

    user_no_hyper_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (decodeHit && !privilegeFlag) |=> !result.hyper)
        else $error("unprivileged trap reached hyper range");

    ordinary_type_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (result.trap && !result.hyper) |-> result.trapTypeValue >= CTD_TT_BASE
            && result.trapTypeValue <= CTD_TT_ORD_MAX)
        else $error("ordinary trap type out of range");

    hyper_type_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        result.hyper |-> result.trapTypeValue >= CTD_TT_HYP_MIN
            && result.trapTypeValue <= CTD_TT_HYP_MAX && $past(privilegeFlag))
        else $error("hyper trap type out of range");

    priv_number_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (takeTrap && privilegeFlag) |=> result.trapTypeValue
            == 9'(CTD_TT_BASE + {1'b0, $past(sum)}))
        else $error("privileged trap number wrong");

    entry_request_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        trapEntryReq |-> result.trap && result.valid && $past(takeTrap))
        else $error("trap entry request without a taken trap");

    wait_single_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low for more than one cycle");

    wait_answer_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        ((avsRead || avsWrite) && avsWaitRequest)
            |=> !avsWaitRequest)
        else $error("request not answered after one wait cycle");

    unsigned_test_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (decodeHit && !illegalEnc && !higherPending
         && instrWord[CTD_COND_HI:CTD_COND_LO] == CTD_C_CS)
            |=> result.trap == $past(groupFlags.c))
        else $error("carry set test gave the wrong outcome");

    sign_test_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (decodeHit && !illegalEnc && !higherPending
         && instrWord[CTD_COND_HI:CTD_COND_LO] == CTD_C_NEG)
            |=> result.trap == $past(groupFlags.n))
        else $error("negative test gave the wrong outcome");

    user_number_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (takeTrap && !privilegeFlag) |=> result.trapTypeValue
            == 9'(CTD_TT_BASE + {2'h0, $past(sum[CTD_USER_NUM_W-1:0])}))
        else $error("unprivileged trap number wrong");

    false_nop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (decodeHit && !illegalEnc && !testTrue)
            |=> result.noEffect && !result.trap)
        else $error("false test did not retire as a no-op");

    pending_blocks_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (decodeHit && higherPending)
            |=> !result.trap && !trapEntryReq)
        else $error("software trap raised over a pending exception");

    trap_entry_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        result.trap
            |-> trapEntryReq && result.valid)
        else $error("taken trap without an entry request");

    last_type_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        result.trap
            |=> lastType == $past(result.trapTypeValue))
        else $error("last trap type not recorded");

    count_step_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (result.trap && !(busWrite && avsAddress == CTD_REG_COUNT))
            |=> trapCount == 16'($past(trapCount) + 16'h0001))
        else $error("trap count did not step");

    ctrl_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ctrlEnable
            |=> !result.valid)
        else $error("instruction decoded while disabled");

    // Set must win even against a clear in the same cycle
    status_sets_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        result.illegal
            |=> status[CTD_EV_ILLEGAL])
        else $error("illegal event not latched in status");

    irq_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        irq
            == (|(status & mask)))
        else $error("interrupt level disagrees with status and mask");

    read_mask_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (avsRead && !avsWaitRequest && avsAddress == CTD_REG_MASK)
            |-> avsReadData == 32'(mask))
        else $error("mask read data wrong");

endmodule : conditional_trap_decoder

//--- tb/ctd_trap_entry_model.sv
module ctd_trap_entry_model
    import ctd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic pendCmd,
    input wire ctd_result_t result,
    input wire logic trapEntryReq,
    output logic higherPending,
    output logic [8:0] savedType
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pending exceptions come only when the bench asks for them
    assign higherPending = pendCmd;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            savedType <= 9'h000;
        end else if (trapEntryReq) begin
            savedType <= result.trapTypeValue;
        end
    end
endmodule : ctd_trap_entry_model

//--- tb/conditional_trap_decoder_test.sv
module conditional_trap_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ctd_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic instrValid = 1'b0;
    logic [31:0] instrWord = 32'h0;
    logic [63:0] src1 = 64'h0;
    logic [63:0] src2 = 64'h0;
    logic [7:0] flagRegister = 8'h0;
    logic privilegeFlag = 1'b0;
    logic pendCmd = 1'b0;
    logic higherPending;
    logic [2:0] trapLevel = 3'h0;
    ctd_result_t result;
    logic trapEntryReq;
    logic [4:0] avsAddress = 5'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [31:0] avsReadData;
    logic avsWaitRequest;
    logic irq;
    logic [8:0] savedType;
    logic [31:0] rd;
    logic en = 1'b1;
    logic [31:0] bad [7];
    int nErrors = 0;
    int nTests = 0;
    int cycles = 0;

    always #5 sys_clk = ~sys_clk;

    conditional_trap_decoder conditional_trap_decoder_i (
        .sys_clk(sys_clk), .resetn(resetn), .instrValid(instrValid),
        .instrWord(instrWord), .firstSourceRegister(src1),
        .secondSourceRegister(src2), .flagRegister(flagRegister),
        .privilegeFlag(privilegeFlag), .higherPending(higherPending),
        .trapLevel(trapLevel), .result(result), .trapEntryReq(trapEntryReq),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .irq(irq)
    );

    ctd_trap_entry_model ctd_trap_entry_model_i (
        .sys_clk(sys_clk), .resetn(resetn), .pendCmd(pendCmd), .result(result),
        .trapEntryReq(trapEntryReq), .higherPending(higherPending),
        .savedType(savedType)
    );

    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", nErrors, nTests);
        if (nErrors == 0 && nTests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            nErrors++;
            end_sim;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        nTests++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic busOp(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= ~wr;
        avsWriteData <= d;
        do @(posedge sys_clk); while (avsWaitRequest !== 1'b0);
        rd = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask : busOp

    function automatic logic [31:0] mk(input logic [3:0] c, input logic i, input logic [1:0] g,
                                       input logic [7:0] lo);
        return {2'b10, 1'b0, c, 6'h3a, 5'h0, i, g, 3'h0, lo};
    endfunction : mk

    function automatic ctd_result_t expResult(input logic [31:0] w, input logic [7:0] s1,
                                              input logic [7:0] s2, input logic [7:0] f,
                                              input logic pr, input logic pd);
        logic [3:0] g;
        logic base;
        logic [7:0] num;
        ctd_result_t e;
        e = '0;
        if (w[31:30] != 2'b10 || w[24:19] != 6'h3a || !en) begin
            return e;
        end
        g = w[12] ? f[7:4] : f[3:0];
        case (w[27:25])
            3'h0: base = 1'b0;
            3'h1: base = g[2];
            3'h2: base = g[2] | (g[3] ^ g[1]);
            3'h3: base = g[3] ^ g[1];
            3'h4: base = g[0] | g[2];
            3'h5: base = g[0];
            3'h6: base = g[3];
            default: base = g[1];
        endcase
        num = s1 + (w[13] ? w[7:0] : s2);
        num[7] = num[7] & pr;
        e.valid = 1'b1;
        e.illegal = w[29] | (w[13] ? |w[10:8] : |w[12:5]) | w[11];
        e.trap = !e.illegal && (w[28] ^ base) && !pd;
        e.hyper = e.trap & num[7];
        e.noEffect = !e.illegal && !e.trap;
        e.level = s1[2:0];
        e.trapTypeValue = e.trap ? 9'h100 + 9'(num) : 9'h0;
        return e;
    endfunction : expResult

    task automatic runInstr(input logic [31:0] w, input logic [7:0] s1, input logic [7:0] s2,
                            input logic [7:0] f, input logic pr, input logic pd);
        ctd_result_t e;
        ctd_result_t got;
        e = expResult(w, s1, s2, f, pr, pd);
        @(posedge sys_clk);
        instrWord <= w;
        src1 <= {56'h0, s1};
        src2 <= {56'h0, s2};
        flagRegister <= f;
        privilegeFlag <= pr;
        pendCmd <= pd;
        trapLevel <= s1[2:0];
        instrValid <= 1'b1;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        #1;
        got = result;
        if (!e.trap) got.trapTypeValue = 9'h0;
        check(e.valid ? 32'(got) : 32'(got.valid), 32'(e), "result");
        check(32'(trapEntryReq), 32'(e.trap), "entry request");
    endtask : runInstr

    task automatic irqAfter(input logic exp);
        repeat (2) @(posedge sys_clk);
        #1;
        check(32'(irq), 32'(exp), "irq");
    endtask : irqAfter

    initial begin
        bad = '{mk(4'h8, 1'b1, 2'b00, 8'h0) | 32'h20000000, mk(4'h8, 1'b0, 2'b00, 8'h20),
                mk(4'h8, 1'b0, 2'b10, 8'h0), mk(4'h8, 1'b1, 2'b00, 8'h0) | 32'h100,
                mk(4'h8, 1'b1, 2'b00, 8'h0) | 32'h400, mk(4'h8, 1'b1, 2'b01, 8'h0),
                mk(4'h8, 1'b1, 2'b11, 8'h0)};
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        busOp(1'b0, CTD_REG_CTRL, 32'h0);
        check(rd, 32'h1, "ctrl reset");
        busOp(1'b0, CTD_REG_MASK, 32'h0);
        check(rd, 32'h0, "mask reset");
        // All sixteen tests, both groups, sums crossing 127
        for (int k = 0; k < 256; k++) begin
            runInstr(mk(k[3:0], 1'b1, {k[4], 1'b0}, k[7:0]), 8'h40, 8'h0, 8'(k * 29), k[5], 1'b0);
        end
        runInstr(mk(4'h8, 1'b0, 2'b00, 8'h0), 8'hf0, 8'h15, 8'h0, 1'b1, 1'b0);
        runInstr(mk(4'h8, 1'b0, 2'b00, 8'h0), 8'hff, 8'h81, 8'h0, 1'b0, 1'b0);
        runInstr(mk(4'h8, 1'b1, 2'b00, 8'h7f), 8'h0, 8'h0, 8'h0, 1'b1, 1'b0);
        runInstr(mk(4'h8, 1'b1, 2'b00, 8'h80), 8'h0, 8'h0, 8'h0, 1'b1, 1'b0);
        runInstr(mk(4'h8, 1'b1, 2'b00, 8'hff), 8'h0, 8'h0, 8'h0, 1'b1, 1'b0);
        for (int k = 0; k < 7; k++) begin
            runInstr(bad[k], 8'h0, 8'h0, 8'h0, 1'b1, 1'b0);
        end
        runInstr(mk(4'h8, 1'b1, 2'b00, 8'h1), 8'h0, 8'h0, 8'h0, 1'b0, 1'b1);
        runInstr(mk(4'h8, 1'b1, 2'b00, 8'h1) | 32'h40000000, 8'h0, 8'h0, 8'h0, 1'b0, 1'b0);
        runInstr(mk(4'h8, 1'b1, 2'b00, 8'h1) ^ 32'h80000, 8'h0, 8'h0, 8'h0, 1'b0, 1'b0);
        // Event registers and the interrupt
        busOp(1'b1, CTD_REG_STATUS, 32'hf);
        busOp(1'b1, CTD_REG_COUNT, 32'h0);
        busOp(1'b1, CTD_REG_MASK, 32'h1);
        runInstr(mk(4'h8, 1'b1, 2'b00, 8'h5), 8'h0, 8'h0, 8'h0, 1'b0, 1'b0);
        irqAfter(1'b1);
        check(32'(savedType), 32'h105, "recorded type");
        busOp(1'b0, CTD_REG_STATUS, 32'h0);
        check(rd, 32'h1, "status");
        busOp(1'b0, CTD_REG_LAST, 32'h0);
        check(rd, 32'h105, "last type");
        busOp(1'b0, CTD_REG_COUNT, 32'h0);
        check(rd, 32'h1, "count");
        busOp(1'b1, CTD_REG_STATUS, 32'h1);
        irqAfter(1'b0);
        // Masked event stays quiet until unmasked
        runInstr(bad[0], 8'h0, 8'h0, 8'h0, 1'b0, 1'b0);
        irqAfter(1'b0);
        busOp(1'b1, CTD_REG_MASK, 32'h4);
        irqAfter(1'b1);
        busOp(1'b1, CTD_REG_STATUS, 32'h4);
        irqAfter(1'b0);
        busOp(1'b1, 5'h1c, 32'hf);
        busOp(1'b0, 5'h1c, 32'h0);
        check(rd, 32'h0, "unmapped");
        busOp(1'b0, CTD_REG_MASK, 32'h0);
        check(rd, 32'h4, "mask kept");
        busOp(1'b1, CTD_REG_CTRL, 32'h0);
        en = 1'b0;
        runInstr(mk(4'h8, 1'b1, 2'b00, 8'h5), 8'h0, 8'h0, 8'h0, 1'b0, 1'b0);
        end_sim;
    end
endmodule : conditional_trap_decoder_test
